// ==== common/host_irq_pkg.sv ====
package host_irq_pkg;

    // Register word addresses on the host register space
    localparam logic [8:0] ROLLOVER_MASK_ADDR = 9'h1DC;
    localparam logic [8:0] STATUS_ADDR = 9'h1E8;
    localparam logic [8:0] HOST_MASK_ADDR = 9'h1EC;

    // Reset values
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_RESET = 32'h00000000;

    // Status bit positions
    localparam int BIT_CLASS = 0;
    localparam int BIT_PAUSE = 1;
    localparam int BIT_NO_BLOCK = 2;
    localparam int BIT_WATER = 3;
    localparam int BIT_TX_START = 4;
    localparam int BIT_TX_DONE = 5;
    localparam int BIT_RX_EARLY = 7;
    localparam int BIT_RX_LATE = 8;
    localparam int BIT_RX_BAD = 11;
    localparam int BIT_TX_BAD = 12;
    localparam int BIT_ROLLOVER = 16;
    localparam int BIT_XCVR = 17;
    localparam int BIT_OVF_UNF = 18;
    localparam int BIT_QUEUE = 19;
    localparam int BIT_WAKE = 20;

    // Implemented latched bits (clear on read) and summary bits
    localparam logic [15:0] LATCH_USED = 16'h19BF;
    localparam logic [31:0] STATUS_USED = 32'h001F19BF;

    // Width of the early receive delay count
    localparam int DELAY_W = 16;
    localparam logic [15:0] DELAY_ONE = 16'h0001;

    // Event pulses from the controller datapath
    typedef struct packed {
        logic classify;
        logic pause_on;
        logic no_block;
        logic water_low;
        logic tx_start;
        logic tx_start_req;
        logic tx_done;
        logic tx_done_req;
        logic rx_start;
        logic rx_late;
        logic rx_bad;
        logic tx_bad;
    } events_t;

    // Summary source levels
    typedef struct packed {
        logic power_event_out;
        logic queue_status_summary;
        logic queue_overflow_underrun_summary;
        logic xcvr_irq;
    } summary_t;

endpackage : host_irq_pkg

// ==== logic/early_rx_delay.sv ====
// Delays the reception-start pulse by a programmed count of cycles
module early_rx_delay #(
    parameter int WIDTH = host_irq_pkg::DELAY_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [WIDTH-1:0] interrupt_delay_count,
    // Result
    output logic fire
);

    logic [WIDTH-1:0] count_q;
    logic busy_q;

    // Restart wins: a new frame start reloads the delay
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_q <= 1'b0;
            count_q <= '0;
            fire <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (start && interrupt_delay_count == '0) begin
                busy_q <= 1'b0; // A zero-delay restart drops any pending count
                fire <= 1'b1;
            end else if (start) begin
                busy_q <= 1'b1;
                count_q <= interrupt_delay_count;
            end else if (busy_q) begin
                if (count_q == WIDTH'(host_irq_pkg::DELAY_ONE)) begin
                    busy_q <= 1'b0;
                    fire <= 1'b1;
                end
                count_q <= count_q - WIDTH'(host_irq_pkg::DELAY_ONE);
            end
        end
    end

    a_delay_exact: assert property (@(posedge clock) disable iff (rst) // see (RULE7)
        start && interrupt_delay_count == WIDTH'(3) ##1 !start [*3] |=> fire)
        else $error("early receive delay wrong");
    a_delay_zero: assert property (@(posedge clock) disable iff (rst) // see (RULE7)
        start && interrupt_delay_count == '0 |=> fire)
        else $error("early receive zero delay wrong");

endmodule : early_rx_delay

// ==== logic/host_interrupt_aggregator.sv ====
// Functional notes
// (RULE1) Rollover mask bit enables interrupt for matching rollover status bit only.
// (RULE2) Host mask bit gates its status bit onto host interrupt only.
// (RULE3) Reading host status clears its latched low sixteen bits.
// (RULE4) Upper summary bits follow sources, never clear on read; bit 20 is power-event low.
// (RULE5) Bit 12 on transmit error, bit 11 on receive error.
// (RULE6) Bit 8 each time a whole frame joins the receive queue.
// (RULE7) Bit 7 on reception start, delayed by interrupt delay count.
// (RULE8) Bit 5 on transmit completion when the control word asks.
// (RULE9) Bit 4 on transmit start when the control word asks.
// (RULE10) Bit 3 when free block count hits the low water mark.
// (RULE11) Bit 2 when a queue wants a block and none is free.
// (RULE12) Bit 1 whenever local pause toggles on or off.
// (RULE13) Interrupt while any status bit and its mask are set; reserved read zero.
module host_interrupt_aggregator (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host register port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Event pulses and summary levels
    input wire host_irq_pkg::events_t events,
    input wire host_irq_pkg::summary_t summary,
    input wire logic [31:0] rx_counter_rollover_status,
    input wire logic [host_irq_pkg::DELAY_W-1:0] interrupt_delay_count,
    // Interrupt
    output logic host_irq
);

    logic [31:0] rx_counter_rollover_mask_q;
    logic [31:0] host_interrupt_mask_q;
    logic [15:0] latch_q;
    logic [31:16] summary_q;
    logic pause_q;
    logic early_fire;
    logic [15:0] set_d;
    logic [31:0] status_view;
    logic status_read;

    early_rx_delay #(.WIDTH(host_irq_pkg::DELAY_W)) u_delay (
        .clock(clock),
        .rst(rst),
        .start(events.rx_start),
        .interrupt_delay_count(interrupt_delay_count),
        .fire(early_fire)
    );

    assign status_read = reg_rd && reg_addr == host_irq_pkg::STATUS_ADDR;
    assign status_view = {summary_q, latch_q};

    // Event set terms for the latched half
    always_comb begin
        set_d = '0;
        set_d[host_irq_pkg::BIT_CLASS] = events.classify;
        set_d[host_irq_pkg::BIT_PAUSE] = events.pause_on != pause_q; // see (RULE12)
        set_d[host_irq_pkg::BIT_NO_BLOCK] = events.no_block; // see (RULE11)
        set_d[host_irq_pkg::BIT_WATER] = events.water_low; // see (RULE10)
        set_d[host_irq_pkg::BIT_TX_START] = events.tx_start && events.tx_start_req; // see (RULE9)
        set_d[host_irq_pkg::BIT_TX_DONE] = events.tx_done && events.tx_done_req; // see (RULE8)
        set_d[host_irq_pkg::BIT_RX_EARLY] = early_fire; // see (RULE7)
        set_d[host_irq_pkg::BIT_RX_LATE] = events.rx_late; // see (RULE6)
        set_d[host_irq_pkg::BIT_RX_BAD] = events.rx_bad; // see (RULE5)
        set_d[host_irq_pkg::BIT_TX_BAD] = events.tx_bad; // see (RULE5)
    end

    // Pause level history for edge detection
    always_ff @(posedge clock) begin
        if (rst) begin
            pause_q <= 1'b0;
        end else begin
            pause_q <= events.pause_on;
        end
    end

    // Latched half; a set in the read cycle survives the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            latch_q <= host_irq_pkg::STATUS_RESET[15:0];
        end else if (status_read) begin
            latch_q <= set_d & host_irq_pkg::LATCH_USED; // see (RULE3) (RULE13)
        end else begin
            latch_q <= (latch_q | set_d) & host_irq_pkg::LATCH_USED;
        end
    end

    // Summary half follows its sources, read has no effect
    always_ff @(posedge clock) begin
        if (rst) begin
            summary_q <= host_irq_pkg::STATUS_RESET[31:16];
        end else begin
            summary_q <= '0; // see (RULE13)
            summary_q[host_irq_pkg::BIT_WAKE] <= !summary.power_event_out; // see (RULE4)
            summary_q[host_irq_pkg::BIT_QUEUE] <= summary.queue_status_summary;
            summary_q[host_irq_pkg::BIT_OVF_UNF] <= summary.queue_overflow_underrun_summary;
            summary_q[host_irq_pkg::BIT_XCVR] <= summary.xcvr_irq;
            summary_q[host_irq_pkg::BIT_ROLLOVER] <=
                |(rx_counter_rollover_status & rx_counter_rollover_mask_q); // see (RULE1)
        end
    end

    // Mask registers
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_counter_rollover_mask_q <= host_irq_pkg::MASK_RESET;
            host_interrupt_mask_q <= host_irq_pkg::MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == host_irq_pkg::ROLLOVER_MASK_ADDR) begin
                rx_counter_rollover_mask_q <= reg_wdata;
            end
            if (reg_addr == host_irq_pkg::HOST_MASK_ADDR) begin
                host_interrupt_mask_q <= reg_wdata;
            end
        end
    end

    // Read data, registered; other addresses read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                host_irq_pkg::ROLLOVER_MASK_ADDR: reg_rdata <= rx_counter_rollover_mask_q;
                host_irq_pkg::STATUS_ADDR: reg_rdata <= status_view;
                host_irq_pkg::HOST_MASK_ADDR: reg_rdata <= host_interrupt_mask_q;
                default: reg_rdata <= '0;
            endcase
        end
    end

    // Interrupt from the registered status view
    always_ff @(posedge clock) begin
        if (rst) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= |(status_view & host_interrupt_mask_q); // see (RULE2) (RULE13)
        end
    end

    // Interrupt and clear-on-read checks
    a_irq_follows: assert property (@(posedge clock) disable iff (rst) // see (RULE2)
        ##1 host_irq == |($past(status_view) & $past(host_interrupt_mask_q)))
        else $error("host interrupt mismatch");
    a_irq_masked: assert property (@(posedge clock) disable iff (rst) // see (RULE2)
        (status_view & host_interrupt_mask_q) == '0 |=> !host_irq)
        else $error("masked status raised interrupt");
    a_read_clears: assert property (@(posedge clock) disable iff (rst) // see (RULE3)
        status_read |=> (latch_q & ~$past(set_d)) == '0)
        else $error("latched bits survived read");
    a_latch_holds: assert property (@(posedge clock) disable iff (rst) // see (RULE3)
        !status_read |=> ($past(latch_q) & ~latch_q) == '0)
        else $error("latched bit dropped without read");
    a_read_data: assert property (@(posedge clock) disable iff (rst) // see (RULE3)
        status_read |=> reg_rdata == $past(status_view))
        else $error("status read data wrong");

    // Summary source checks
    a_wake_level: assert property (@(posedge clock) disable iff (rst) // see (RULE4)
        !summary.power_event_out |=> summary_q[host_irq_pkg::BIT_WAKE])
        else $error("wake bit wrong");
    a_wake_clears: assert property (@(posedge clock) disable iff (rst) // see (RULE4)
        summary.power_event_out |=> !summary_q[host_irq_pkg::BIT_WAKE])
        else $error("wake bit stuck");
    a_queue_follows: assert property (@(posedge clock) disable iff (rst) // see (RULE4)
        summary.queue_status_summary |=> summary_q[host_irq_pkg::BIT_QUEUE])
        else $error("queue summary missed");
    a_ovf_follows: assert property (@(posedge clock) disable iff (rst) // see (RULE4)
        summary.queue_overflow_underrun_summary |=> summary_q[host_irq_pkg::BIT_OVF_UNF])
        else $error("overflow summary missed");
    a_xcvr_follows: assert property (@(posedge clock) disable iff (rst) // see (RULE4)
        summary.xcvr_irq |=> summary_q[host_irq_pkg::BIT_XCVR])
        else $error("transceiver summary missed");

    // Event set checks
    a_tx_bad_sets: assert property (@(posedge clock) disable iff (rst) // see (RULE5)
        events.tx_bad |=> latch_q[host_irq_pkg::BIT_TX_BAD])
        else $error("tx bad not set");
    a_rx_bad_sets: assert property (@(posedge clock) disable iff (rst) // see (RULE5)
        events.rx_bad |=> latch_q[host_irq_pkg::BIT_RX_BAD])
        else $error("rx bad not set");
    a_rx_late_sets: assert property (@(posedge clock) disable iff (rst) // see (RULE6)
        events.rx_late |=> latch_q[host_irq_pkg::BIT_RX_LATE])
        else $error("rx late not set");
    a_early_sets: assert property (@(posedge clock) disable iff (rst) // see (RULE7)
        early_fire |=> latch_q[host_irq_pkg::BIT_RX_EARLY])
        else $error("early receive not set");
    a_tx_done_gate: assert property (@(posedge clock) disable iff (rst) // see (RULE8)
        events.tx_done && events.tx_done_req |=> latch_q[host_irq_pkg::BIT_TX_DONE])
        else $error("tx done not set");
    a_tx_start_gate: assert property (@(posedge clock) disable iff (rst) // see (RULE9)
        events.tx_start && events.tx_start_req |=> latch_q[host_irq_pkg::BIT_TX_START])
        else $error("tx start not set");
    a_pause_toggle: assert property (@(posedge clock) disable iff (rst) // see (RULE12)
        $changed(events.pause_on) |-> ##1 latch_q[host_irq_pkg::BIT_PAUSE])
        else $error("pause change missed");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // see (RULE13)
        (status_view & ~host_irq_pkg::STATUS_USED) == '0)
        else $error("reserved bit set");
    a_roll_masked: assert property (@(posedge clock) disable iff (rst) // see (RULE1)
        (rx_counter_rollover_status & rx_counter_rollover_mask_q) == '0
        |=> !summary_q[host_irq_pkg::BIT_ROLLOVER])
        else $error("masked rollover raised");
    a_water_sets: assert property (@(posedge clock) disable iff (rst) // see (RULE10)
        events.water_low |=> latch_q[host_irq_pkg::BIT_WATER])
        else $error("water mark missed");
    a_no_block_sets: assert property (@(posedge clock) disable iff (rst) // see (RULE11)
        events.no_block |=> latch_q[host_irq_pkg::BIT_NO_BLOCK])
        else $error("no block missed");

    // Register port checks
    a_hmask_write: assert property (@(posedge clock) disable iff (rst) // see (RULE2)
        reg_wr && reg_addr == host_irq_pkg::HOST_MASK_ADDR |=> host_interrupt_mask_q == $past(reg_wdata))
        else $error("host mask write lost");
    a_rmask_write: assert property (@(posedge clock) disable iff (rst) // see (RULE1)
        reg_wr && reg_addr == host_irq_pkg::ROLLOVER_MASK_ADDR |=> rx_counter_rollover_mask_q == $past(reg_wdata))
        else $error("rollover mask write lost");

    // Main scenarios
    c_irq_rise: cover property (@(posedge clock) disable iff (rst) $rose(host_irq));
    c_read_clear: cover property (@(posedge clock) disable iff (rst) status_read && latch_q != '0);
    c_early_rx: cover property (@(posedge clock) disable iff (rst) early_fire);
    c_wake: cover property (@(posedge clock) disable iff (rst) summary_q[host_irq_pkg::BIT_WAKE]);
    c_pause_edge: cover property (@(posedge clock) disable iff (rst) set_d[host_irq_pkg::BIT_PAUSE]);

endmodule : host_interrupt_aggregator

// ==== verification/host_model.sv ====
// Host processor side of the register port
module host_model (
    // Clock and returned data
    input wire logic clock,
    input wire logic [31:0] reg_rdata,
    // Register strobes
    output logic reg_rd,
    output logic reg_wr,
    output logic [8:0] reg_addr,
    output logic [31:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 32'h00000000;
    end

    // One-cycle write strobe; launched off the falling edge so no race
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr

    // One-cycle read strobe; data is registered, so taken a cycle later
    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : host_model

// ==== verification/host_interrupt_aggregator_tb.sv ====
module host_interrupt_aggregator_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rst, reg_rd, reg_wr, host_irq;
    logic [8:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rollover, got, hmask, rmask;
    logic [15:0] delay;
    host_irq_pkg::events_t events;
    host_irq_pkg::summary_t summary;
    int n_mismatch, samples_checked;
    int nd;
    // Model: latched status positions still waiting for a status read
    int pend [$];
    // Event patterns and the status bit each should latch (-1: none)
    logic [11:0] pat [11] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h0C0, 12'h030,
        12'h004, 12'h002, 12'h001, 12'h080, 12'h020};
    int pos [11] = '{0, 1, 2, 3, 4, 5, 8, 11, 12, -1, -1};
    logic [8:0] addrs [4] = '{host_irq_pkg::ROLLOVER_MASK_ADDR, host_irq_pkg::STATUS_ADDR,
        host_irq_pkg::HOST_MASK_ADDR, 9'h100};

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    host_interrupt_aggregator dut (.clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .events(events),
        .summary(summary), .rx_counter_rollover_status(rollover), .interrupt_delay_count(delay),
        .host_irq(host_irq));
    host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rd_chk(input string name, input logic [8:0] a, input logic [31:0] exp);
        host.rd(a, got);
        chk(name, exp, got);
    endtask : rd_chk

    // Model of the status word: summary half from the sources, latched half from pending events
    function automatic logic [31:0] model_status();
        logic [31:0] v;
        v = 32'h00000000;
        v[host_irq_pkg::BIT_WAKE] = !summary.power_event_out;
        v[host_irq_pkg::BIT_QUEUE] = summary.queue_status_summary;
        v[host_irq_pkg::BIT_OVF_UNF] = summary.queue_overflow_underrun_summary;
        v[host_irq_pkg::BIT_XCVR] = summary.xcvr_irq;
        v[host_irq_pkg::BIT_ROLLOVER] = |(rollover & rmask);
        foreach (pend[j]) v[pend[j]] = 1'b1;
        return v;
    endfunction : model_status

    // Status read against the model; the read empties the latched half
    task automatic rd_status(input string name);
        rd_chk(name, host_irq_pkg::STATUS_ADDR, model_status());
        pend.delete();
    endtask : rd_status

    task automatic report_and_stop();
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard, far beyond the under two hundred cycles the run needs
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        events = '0;
        summary = host_irq_pkg::summary_t'(4'h8);
        rollover = 32'h00000000;
        delay = 16'h0001;
        hmask = 32'h00000000;
        rmask = 32'h00000000;
        void'($urandom(32'h4432));
        repeat (3) @(negedge clock);
        rst = 1'b0;
        // Reset values, unmapped place reads zero
        for (int i = 0; i < 4; i++) rd_chk("reset", addrs[i], 32'h00000000);
        chk("irq_reset", 32'h00000000, {31'h0, host_irq});
        hmask = $urandom();
        rmask = $urandom();
        host.wr(host_irq_pkg::HOST_MASK_ADDR, hmask);
        host.wr(host_irq_pkg::ROLLOVER_MASK_ADDR, rmask);
        host.wr(host_irq_pkg::STATUS_ADDR, 32'hFFFFFFFF);
        rd_chk("host_mask", host_irq_pkg::HOST_MASK_ADDR, hmask);
        rd_chk("roll_mask", host_irq_pkg::ROLLOVER_MASK_ADDR, rmask);
        rd_status("status_wr");
        // Each event latches its bit (transmit start or done without its request latches none), gated onto the interrupt, cleared by a read
        for (int i = 0; i < 11; i++) begin
            @(negedge clock);
            events = host_irq_pkg::events_t'(pat[i]);
            @(negedge clock);
            events = '0;
            if (pos[i] >= 0) begin
                pend.push_back(pos[i]);
            end
            @(negedge clock);
            chk("irq_set", {31'h0, |(model_status() & hmask)}, {31'h0, host_irq});
            rd_status("event");
            repeat (2) @(negedge clock);
            chk("irq_clr", {31'h0, |(model_status() & hmask)}, {31'h0, host_irq});
            rd_status("cleared");
        end
        // Early receive bit waits for the programmed delay: none, three, then a random one
        for (int k = 0; k < 3; k++) begin
            nd = (k == 0) ? 0 : (k == 1) ? 3 : int'($urandom_range(6, 1));
            delay = 16'(nd);
            @(negedge clock);
            events = host_irq_pkg::events_t'(12'h008);
            @(negedge clock);
            events = '0;
            if (nd > 0) begin
                repeat (nd - 1) @(negedge clock);
                rd_status("early_wait");
            end
            pend.push_back(host_irq_pkg::BIT_RX_EARLY);
            rd_status("early_set");
        end
        // Summary bits follow sources and survive reads; rollover overlaps the mask on purpose
        rollover = $urandom() | rmask;
        summary = host_irq_pkg::summary_t'(4'h7);
        repeat (3) @(negedge clock);
        chk("irq_sum", {31'h0, |(model_status() & hmask)}, {31'h0, host_irq});
        rd_status("summary");
        rd_status("sum_kept");
        rmask = 32'h00000000;
        host.wr(host_irq_pkg::ROLLOVER_MASK_ADDR, rmask);
        repeat (2) @(negedge clock);
        rd_status("roll_off");
        summary = host_irq_pkg::summary_t'(4'h8);
        rollover = 32'h00000000;
        repeat (3) @(negedge clock);
        rd_status("sum_gone");
        // Second reset in mid-run, with an event latched and the host mask set
        events = host_irq_pkg::events_t'(12'h001);
        @(negedge clock);
        events = '0;
        rst = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        hmask = 32'h00000000;
        chk("rst_irq", 32'h00000000, {31'h0, host_irq});
        rd_chk("rst_mask", host_irq_pkg::HOST_MASK_ADDR, hmask);
        rd_chk("rst_roll", host_irq_pkg::ROLLOVER_MASK_ADDR, rmask);
        rd_status("rst_status");
        report_and_stop();
    end
endmodule : host_interrupt_aggregator_tb
